// ---- hdl/irq_regs_defs.vh ----
// Register offsets, field positions, reset values and vectors of the interrupt register block
`ifndef IRQ_REGS_DEFS_VH
`define IRQ_REGS_DEFS_VH

// Register byte addresses on the special-function bus
`define OFS_TIMER_CTL 8'h88
`define OFS_SERIAL_CTL 8'h98
`define OFS_IRQ_EN_TWO 8'h9A
`define OFS_PRIO_LOW 8'hA9
`define OFS_IRQ_EN_ZERO 8'hA8
`define OFS_PRIO_HIGH 8'hB9
`define OFS_IRQ_REQ_TWO 8'hBF
`define OFS_IRQ_ACTIVE 8'hC0
`define OFS_CORE_STAT 8'hC1
`define OFS_CORE_MASK 8'hC2

// Enable register zero fields
`define BIT_GLOBAL_EN 7
`define BIT_SERIAL_EN 4
`define BIT_T1_EN 3
`define BIT_P1_EN 2
`define BIT_T0_EN 1
`define BIT_P0_EN 0
`define MASK_EN_ZERO 8'h9F

// Enable two and request two fields
`define BIT_P2 2
`define BIT_T3 1
`define BIT_ADC 0
`define MASK_TWO 8'h07

// Timer control fields
`define BIT_T1_REQ 7
`define BIT_T0_REQ 5
`define BIT_P1_REQ 3
`define BIT_P0_REQ 1
`define MASK_TIMER_CONTROL_FLAGS 8'hAA

// Serial control fields
`define BIT_TX_REQ 1
`define BIT_RX_REQ 0
`define MASK_SCON 8'h03

// Priority registers hold six groups
`define MASK_PRIO 8'h3F
`define RESET_BYTE 8'h00

// Fixed vectors
`define VEC_RESET 16'h0000
`define VEC_P0 16'h0003
`define VEC_T0 16'h000B
`define VEC_P2 16'h0083
`define VEC_ADC 16'h008B
`define VEC_P1 16'h0013
`define VEC_T1 16'h001B
`define VEC_SERIAL 16'h0023
`define VEC_T3 16'h00EB

`endif

// ---- hdl/irq_regs.v ----
// Interrupt enable, request flag, priority and vector logic with an Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "irq_regs_defs.vh"

module irq_regs (
    // Clock, reset, enable
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_clk_en,
    // Avalon-MM slave
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // Source events, one-cycle pulses from peripherals on this clock
    input wire i_ev_pin_zero,
    input wire i_ev_pin_one,
    input wire i_ev_pin_two,
    input wire i_ev_timer_zero,
    input wire i_ev_timer_one,
    input wire i_ev_timer_three,
    input wire i_ev_adc,
    input wire i_ev_serial_tx,
    input wire i_ev_serial_rx,
    // Core side
    output reg o_irq_req,
    output reg [15:0] o_irq_vector,
    input wire i_irq_ack,
    input wire i_irq_return,
    // Summary interrupt
    output wire o_irq
);

    // Source indices in natural order
    localparam S_P0 = 3'd0;
    localparam S_P2 = 3'd1;
    localparam S_T0 = 3'd2;
    localparam S_ADC = 3'd3;
    localparam S_P1 = 3'd4;
    localparam S_T1 = 3'd5;
    localparam S_SER = 3'd6;
    localparam S_T3 = 3'd7;

    reg [7:0] en_zero_reg;
    reg [7:0] en_two_reg;
    reg [7:0] req_two_reg;
    reg [7:0] timer_control_flags_reg;
    reg [7:0] scon_reg;
    reg [7:0] prio_low_reg;
    reg [7:0] prio_high_reg;
    reg [3:0] active_reg;
    reg [7:0] core_stat_reg;
    reg [7:0] core_mask_reg;
    // Source and level on offer, so the clear and the stack follow what the core took
    reg [2:0] req_src_reg;
    reg [1:0] req_lvl_reg;
    // Read wait state: data comes from a flop, so the first read cycle is stalled
    reg rd_ready_reg;

    // Next values of the software-visible registers
    reg [7:0] en_zero_next;
    reg [7:0] en_two_next;
    reg [7:0] req_two_next;
    reg [7:0] timer_control_flags_next;
    reg [7:0] scon_next;
    reg [7:0] prio_low_next;
    reg [7:0] prio_high_next;
    reg [7:0] core_stat_next;
    reg [7:0] core_mask_next;
    reg [3:0] active_next;
    reg [31:0] rdata_next;

    // Bus decode
    wire wr = i_avs_write & i_avs_byteenable[0] & i_clk_en;
    wire [7:0] wd = i_avs_writedata[7:0];
    // A read stalls one cycle while its data is registered; a write stalls only while frozen
    assign o_avs_waitrequest = (i_avs_read & ~rd_ready_reg) | (i_avs_write & ~i_clk_en);

    // Group of each source
    function [2:0] grp_of;
        input [2:0] s;
        begin
            case (s)
                S_P0, S_P2: grp_of = 3'd0;
                S_T0, S_ADC: grp_of = 3'd1;
                S_P1: grp_of = 3'd2;
                S_T1: grp_of = 3'd3;
                S_SER: grp_of = 3'd4;
                default: grp_of = 3'd5;
            endcase
        end
    endfunction

    // Vector of each source
    function [15:0] vec_of;
        input [2:0] s;
        begin
            case (s)
                S_P0: vec_of = `VEC_P0;
                S_P2: vec_of = `VEC_P2;
                S_T0: vec_of = `VEC_T0;
                S_ADC: vec_of = `VEC_ADC;
                S_P1: vec_of = `VEC_P1;
                S_T1: vec_of = `VEC_T1;
                S_SER: vec_of = `VEC_SERIAL;
                default: vec_of = `VEC_T3;
            endcase
        end
    endfunction

    // One-hot bit of a priority level in the running stack
    function [3:0] lvl_bit;
        input [1:0] l;
        begin
            lvl_bit = 4'd1 << l;
        end
    endfunction

    // Flags and enables gathered in natural order
    wire [7:0] flags = {req_two_reg[`BIT_T3],
        scon_reg[`BIT_TX_REQ] | scon_reg[`BIT_RX_REQ],
        timer_control_flags_reg[`BIT_T1_REQ], timer_control_flags_reg[`BIT_P1_REQ], req_two_reg[`BIT_ADC],
        timer_control_flags_reg[`BIT_T0_REQ], req_two_reg[`BIT_P2], timer_control_flags_reg[`BIT_P0_REQ]};
    wire [7:0] enables = {en_two_reg[`BIT_T3], en_zero_reg[`BIT_SERIAL_EN],
        en_zero_reg[`BIT_T1_EN], en_zero_reg[`BIT_P1_EN], en_two_reg[`BIT_ADC],
        en_zero_reg[`BIT_T0_EN], en_two_reg[`BIT_P2], en_zero_reg[`BIT_P0_EN]};
    // Global gate: nothing is taken with the global enable low
    wire [7:0] pending = flags & enables & {8{en_zero_reg[`BIT_GLOBAL_EN]}};

    // Pick the highest level, then the first in natural order
    reg [2:0] win_src;
    reg [1:0] win_lvl;
    reg win_any;
    reg [1:0] lvl;
    integer k;
    always @* begin
        win_src = 3'd0;
        win_lvl = 2'd0;
        win_any = 1'b0;
        lvl = 2'd0;
        for (k = 0; k < 8; k = k + 1) begin
            lvl = {prio_high_reg[grp_of(k[2:0])], prio_low_reg[grp_of(k[2:0])]};
            // Strictly greater keeps the earlier source on a tie
            if (pending[k] && (!win_any || lvl > win_lvl)) begin
                win_any = 1'b1;
                win_lvl = lvl;
                win_src = k[2:0];
            end
        end
    end

    // Running level: the highest set bit of the active stack
    wire run_any = |active_reg;
    wire [1:0] run_lvl = active_reg[3] ? 2'd3 : active_reg[2] ? 2'd2 :
        active_reg[1] ? 2'd1 : 2'd0;
    // Only a strictly higher level preempts a running routine
    wire can_take = win_any && (!run_any || win_lvl > run_lvl);
    wire take = o_irq_req & i_irq_ack & i_clk_en;
    // A return only counts while some routine runs
    wire ret_ok = i_irq_return & run_any & i_clk_en;
    // Clear the source that was offered, not the current winner, which may have moved
    wire [7:0] auto_clr = (take && req_src_reg != S_SER) ?
        (8'h01 << req_src_reg) : 8'h00;

    // Write masks, byte lane zero only
    wire w_en0 = wr && i_avs_address == `OFS_IRQ_EN_ZERO;
    wire w_en2 = wr && i_avs_address == `OFS_IRQ_EN_TWO;
    wire w_rq2 = wr && i_avs_address == `OFS_IRQ_REQ_TWO;
    wire w_tc = wr && i_avs_address == `OFS_TIMER_CTL;
    wire w_sc = wr && i_avs_address == `OFS_SERIAL_CTL;
    wire w_pl = wr && i_avs_address == `OFS_PRIO_LOW;
    wire w_ph = wr && i_avs_address == `OFS_PRIO_HIGH;
    wire w_cs = wr && i_avs_address == `OFS_CORE_STAT;
    wire w_cm = wr && i_avs_address == `OFS_CORE_MASK;

    // Event vectors in register layout
    wire [7:0] ev_two = {5'd0, i_ev_pin_two, i_ev_timer_three, i_ev_adc};
    wire [7:0] ev_tc = {i_ev_timer_one, 1'b0, i_ev_timer_zero, 1'b0, i_ev_pin_one, 1'b0,
        i_ev_pin_zero, 1'b0};
    wire [7:0] ev_sc = {6'd0, i_ev_serial_tx, i_ev_serial_rx};
    wire [7:0] clr_two = {5'd0, auto_clr[S_P2], auto_clr[S_T3], auto_clr[S_ADC]};
    wire [7:0] clr_tc = {auto_clr[S_T1], 1'b0, auto_clr[S_T0], 1'b0, auto_clr[S_P1], 1'b0,
        auto_clr[S_P0], 1'b0};

    // Core status events: bit 7 for any accepted vector and bit 6 for a return
    wire [7:0] core_ev = {take, ret_ok, 6'd0};

    // Enable, priority and mask registers change only by software
    always @* begin
        en_zero_next = en_zero_reg;
        en_two_next = en_two_reg;
        prio_low_next = prio_low_reg;
        prio_high_next = prio_high_reg;
        core_mask_next = core_mask_reg;
        if (w_en0) begin
            en_zero_next = wd & `MASK_EN_ZERO;
        end
        if (w_en2) begin
            en_two_next = wd & `MASK_TWO;
        end
        if (w_pl) begin
            prio_low_next = wd & `MASK_PRIO;
        end
        if (w_ph) begin
            prio_high_next = wd & `MASK_PRIO;
        end
        if (w_cm) begin
            core_mask_next = wd & 8'hC0;
        end
    end

    // Request flags: software may write them; the event term is ORed last so a set wins
    always @* begin
        req_two_next = w_rq2 ? wd : req_two_reg;
        req_two_next = req_two_next & ~clr_two;
        req_two_next = (req_two_next | ev_two) & `MASK_TWO;
        timer_control_flags_next = w_tc ? wd : timer_control_flags_reg;
        timer_control_flags_next = timer_control_flags_next & ~clr_tc;
        timer_control_flags_next = (timer_control_flags_next | ev_tc) & `MASK_TIMER_CONTROL_FLAGS;
        // Serial flags: hardware only sets them and never clears them
        scon_next = w_sc ? wd : scon_reg;
        scon_next = (scon_next | ev_sc) & `MASK_SCON;
        // Core status is write-one-to-clear; a fresh event wins
        core_stat_next = core_stat_reg & ~(w_cs ? wd : 8'h00);
        core_stat_next = core_stat_next | core_ev;
    end

    // Register update; a low clock enable holds everything
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            // Every flag, enable and level clears on reset
            en_zero_reg <= `RESET_BYTE;
            en_two_reg <= `RESET_BYTE;
            req_two_reg <= `RESET_BYTE;
            timer_control_flags_reg <= `RESET_BYTE;
            scon_reg <= `RESET_BYTE;
            prio_low_reg <= `RESET_BYTE;
            prio_high_reg <= `RESET_BYTE;
            core_stat_reg <= `RESET_BYTE;
            core_mask_reg <= `RESET_BYTE;
        end else if (i_clk_en) begin
            // Software registers
            en_zero_reg <= en_zero_next;
            en_two_reg <= en_two_next;
            prio_low_reg <= prio_low_next;
            prio_high_reg <= prio_high_next;
            core_mask_reg <= core_mask_next;
            // Flags
            req_two_reg <= req_two_next;
            timer_control_flags_reg <= timer_control_flags_next;
            scon_reg <= scon_next;
            core_stat_reg <= core_stat_next;
        end
    end

    // Running-level stack: a return ends the highest level, a take opens the offered level
    always @* begin
        active_next = active_reg;
        if (ret_ok) begin
            active_next = active_next & ~lvl_bit(run_lvl);
        end
        if (take) begin
            active_next = active_next | lvl_bit(req_lvl_reg);
        end
    end

    // Core handshake; the offer is re-evaluated each cycle so it tracks the current winner
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_irq_req <= 1'b0;
            o_irq_vector <= `VEC_RESET;
            req_src_reg <= 3'd0;
            req_lvl_reg <= 2'd0;
            active_reg <= 4'd0;
        end else if (i_clk_en) begin
            // The stack moves with every take and return
            active_reg <= active_next;
            if (take || ret_ok) begin
                // Hold off one cycle so the cleared flag and the new level are seen first
                o_irq_req <= 1'b0;
            end else begin
                o_irq_req <= can_take;
                o_irq_vector <= vec_of(win_src);
                req_src_reg <= win_src;
                req_lvl_reg <= win_lvl;
            end
        end
    end

    // Summary interrupt: any unmasked core status bit
    assign o_irq = |(core_stat_reg & core_mask_reg);

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        rdata_next = 32'h00000000;
        case (i_avs_address)
            `OFS_IRQ_EN_ZERO: rdata_next[7:0] = en_zero_reg;
            `OFS_IRQ_EN_TWO: rdata_next[7:0] = en_two_reg;
            `OFS_IRQ_REQ_TWO: rdata_next[7:0] = req_two_reg;
            `OFS_TIMER_CTL: rdata_next[7:0] = timer_control_flags_reg;
            `OFS_SERIAL_CTL: rdata_next[7:0] = scon_reg;
            `OFS_PRIO_LOW: rdata_next[7:0] = prio_low_reg;
            `OFS_PRIO_HIGH: rdata_next[7:0] = prio_high_reg;
            `OFS_IRQ_ACTIVE: rdata_next[7:0] = {4'd0, active_reg};
            `OFS_CORE_STAT: rdata_next[7:0] = core_stat_reg;
            `OFS_CORE_MASK: rdata_next[7:0] = core_mask_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // Read data is loaded in the stalled first cycle and stands while waitrequest is low
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h00000000;
            rd_ready_reg <= 1'b0;
        end else if (i_clk_en) begin
            rd_ready_reg <= i_avs_read & ~rd_ready_reg;
            if (i_avs_read && !rd_ready_reg) begin
                o_avs_readdata <= rdata_next;
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/irq_regs_asserts.sv ----
// Port checker for the interrupt register block
`timescale 1ns/1ns
`default_nettype none
module irq_regs_asserts (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Register bus
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Core side
    input wire logic o_irq_req,
    input wire logic [15:0] o_irq_vector,
    input wire logic i_irq_ack,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic unmapped_rd;
    logic en_off_wr;
    // Reads outside the map must come back empty
    assign unmapped_rd = i_avs_read && !(i_avs_address inside {8'h88, 8'h98, 8'h9A, 8'hA8,
        8'hA9, 8'hB9, 8'hBF, 8'hC0, 8'hC1, 8'hC2});
    // A taken write that clears the global enable
    assign en_off_wr = i_avs_write && i_avs_byteenable[0] && i_clk_en
        && i_avs_address == 8'hA8 && !i_avs_writedata[7];
    rst_vector_a: assert property (disable iff (1'b0) i_sys_rst |=>
        o_irq_vector == 16'h0000 && !o_irq_req) else $error("vector not cleared by reset");
    vector_set_a: assert property (o_irq_req |-> o_irq_vector inside {16'h0003, 16'h0083,
        16'h000B, 16'h008B, 16'h0013, 16'h001B, 16'h0023, 16'h00EB}) else $error("bad vector");
    ack_drop_a: assert property (o_irq_req && i_irq_ack && i_clk_en |=> !o_irq_req)
        else $error("request held after ack");
    upper_zero_a: assert property (o_avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_read_a: assert property (unmapped_rd |=> o_avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    en_two_a: assert property (i_avs_read && i_avs_address == 8'h9A |=>
        o_avs_readdata[7:3] == 5'h00) else $error("enable two reserved bits set");
    req_two_a: assert property (i_avs_read && i_avs_address == 8'hBF |=>
        o_avs_readdata[7:3] == 5'h00) else $error("request two reserved bits set");
    en_zero_a: assert property (i_avs_read && i_avs_address == 8'hA8 |=>
        o_avs_readdata[6:5] == 2'h0) else $error("enable zero reserved bits set");
    global_off_a: assert property (en_off_wr |=> ##1 !o_irq_req)
        else $error("request with global enable clear");
    read_stall_a: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
        else $error("read not stalled for its data");
    read_ready_a: assert property (i_avs_read && o_avs_waitrequest && i_clk_en |=>
        !(i_avs_read && o_avs_waitrequest)) else $error("read stalled twice");
    cover property (o_irq_req && i_irq_ack);
    cover property (o_irq_req && o_irq_vector == 16'h00EB);
    cover property (o_irq);
endmodule
`default_nettype wire

// ---- tb/core_model.sv ----
// Behavioural core that takes vectors, runs a routine and returns
`timescale 1ns/1ns
`default_nettype none
module core_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Request side
    input wire logic i_irq_req,
    input wire logic [7:0] i_delay,
    // Answer side
    output logic o_irq_ack,
    output logic o_irq_return,
    output logic [3:0] o_depth
);
    logic [7:0] wait_cnt;
    logic [7:0] isr_cnt;
    // Each ack opens a nested routine; a fixed length keeps preemption windows predictable
    always @(posedge i_mclk) begin
        o_irq_ack <= 1'b0;
        o_irq_return <= 1'b0;
        if (i_sys_rst) begin
            wait_cnt <= 8'h00;
            isr_cnt <= 8'h00;
            o_depth <= 4'h0;
        end else if (i_irq_req && !o_irq_ack && wait_cnt >= i_delay) begin
            o_irq_ack <= 1'b1;
            wait_cnt <= 8'h00;
            isr_cnt <= 8'h14;
            o_depth <= o_depth + 4'h1;
        end else begin
            wait_cnt <= i_irq_req ? wait_cnt + 8'h01 : 8'h00;
            if (o_depth != 4'h0 && isr_cnt == 8'h00) begin
                o_irq_return <= 1'b1;
                o_depth <= o_depth - 4'h1;
                isr_cnt <= 8'h14;
            end else if (isr_cnt != 8'h00) begin
                isr_cnt <= isr_cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the interrupt register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, rd_r = 1'b0, wr_r = 1'b0;
    logic [7:0] addr = 8'h00, delay = 8'h01;
    logic [31:0] wdata = 32'h0, o_avs_readdata, e;
    logic [3:0] be = 4'hF, dep;
    logic [8:0] ev = 9'h000;
    logic o_avs_waitrequest, irq_req, ack, ret, o_irq;
    logic [15:0] vec;
    logic [19:0] v;
    logic [31:0] seed = 32'h0000F385;
    logic [31:0] rq[$];
    logic [19:0] vq[$];
    int fail_count = 0, n_tests = 0;
    irq_regs uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_avs_address(addr), .i_avs_read(rd_r), .i_avs_write(wr_r), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_ev_pin_zero(ev[0]), .i_ev_pin_one(ev[1]), .i_ev_pin_two(ev[2]), .i_ev_timer_zero(ev[3]),
        .i_ev_timer_one(ev[4]), .i_ev_timer_three(ev[5]), .i_ev_adc(ev[6]), .i_ev_serial_tx(ev[7]),
        .i_ev_serial_rx(ev[8]), .o_irq_req(irq_req), .o_irq_vector(vec), .i_irq_ack(ack),
        .i_irq_return(ret), .o_irq(o_irq));
    core_model core (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_irq_req(irq_req),
        .i_delay(delay), .o_irq_ack(ack), .o_irq_return(ret), .o_depth(dep));
    initial forever #5 i_mclk = ~i_mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Write holds until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= {24'h000000, d};
        wr_r <= 1'b1;
        do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
        wr_r <= 1'b0;
    endtask
    // Read holds until waitrequest is seen low; the watcher takes the data at that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_mclk);
        addr <= a;
        rd_r <= 1'b1;
        rq.push_back({24'h000000, x});
        do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
        rd_r <= 1'b0;
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge i_mclk);
        ev <= m;
        @(posedge i_mclk);
        ev <= 9'h000;
    endtask
    task automatic drain;
        for (int k = 0; k < 3000 && vq.size() != 0; k++) @(posedge i_mclk);
        repeat (30) @(posedge i_mclk);
    endtask
    // Results are matched against the oldest noted expectation
    always @(posedge i_mclk) begin
        if (rd_r && o_avs_waitrequest === 1'b0) begin
            e = rq.pop_front();
            `CHK("readdata", e, o_avs_readdata)
        end
        if (ack && irq_req) begin
            v = vq.pop_front();
            `CHK("vector", v, {dep, vec})
        end
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(8'h55, 8'h00);
        rd(8'h88, 8'h00); rd(8'h98, 8'h00); rd(8'h9A, 8'h00); rd(8'hA8, 8'h00);
        rd(8'hBF, 8'h00); rd(8'hA9, 8'h00); rd(8'hB9, 8'h00);
        be <= 4'hE;
        wr(8'hA8, 8'hFF);
        be <= 4'hF;
        rd(8'hA8, 8'h00);
        repeat (6) begin
            seed = xs(seed);
            wr(8'h9A, seed[7:0]); rd(8'h9A, seed[7:0] & 8'h07);
            wr(8'hA8, seed[15:8]); rd(8'hA8, seed[15:8] & 8'h9F);
        end
        wr(8'hA8, 8'h00); wr(8'h9A, 8'h00);
        pulse(9'h1FF);
        repeat (4) @(posedge i_mclk);
        rd(8'h88, 8'hAA); rd(8'hBF, 8'h07); rd(8'h98, 8'h03);
        wr(8'h98, 8'h00); rd(8'h98, 8'h00);
        wr(8'h88, 8'h55); rd(8'h88, 8'h00);
        wr(8'hBF, 8'h00);
        delay <= {5'h00, seed[18:16]};
        // Top nibble: routine depth the core reports once it has acked
        vq = '{20'h10003, 20'h10083, 20'h1000B, 20'h1008B, 20'h10013, 20'h1001B, 20'h100EB};
        wr(8'h9A, 8'h07); wr(8'hA8, 8'h8F);
        pulse(9'h07F);
        drain();
        rd(8'h88, 8'h00); rd(8'hBF, 8'h00);
        #1 `CHK("irq", 1'b0, o_irq)
        wr(8'hC2, 8'hC0);
        #1 `CHK("irq", 1'b1, o_irq)
        rd(8'hC1, 8'hC0);
        wr(8'hC1, 8'h80); rd(8'hC1, 8'h40);
        wr(8'hC1, 8'h40);
        #1 `CHK("irq", 1'b0, o_irq)
        // A frozen block must not take an event
        i_clk_en <= 1'b0;
        pulse(9'h008);
        i_clk_en <= 1'b1;
        rd(8'h88, 8'h00);
        delay <= 8'h01;
        wr(8'hA9, 8'h20); wr(8'hB9, 8'h20);
        vq = '{20'h10003, 20'h200EB};
        pulse(9'h001);
        repeat (6) @(posedge i_mclk);
        pulse(9'h020);
        drain();
        end_sim();
    end
endmodule
bind irq_regs irq_regs_asserts u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector), .i_irq_ack(i_irq_ack), .o_irq(o_irq));
`default_nettype wire
